// File: rtl/smsf_dev.sv
// memory end of the serial link: pin sampling, command framing, array and status
// assumes pins come from another domain and are slow against core_clk
`timescale 1ns/1ns
`default_nettype none
`include "smsf_map.svh"

// Summary of operation
// - byte array of 131072 eight-bit locations
// - three address bytes, top seven ignored
// - first byte after select is opcode
// - select fall starts command, one opcode
// - deselected: input ignored, output released
// - sample on sck rise, shift on fall
// - first rise after select takes first bit
// - every byte moves msb first
// - clock level at select picks mode 0/3
// - bad opcode: ignore input until next select
// - writes finish at bus speed, never busy
// - eight-bit configuration and status register
// - master keeps sck at or below 40 MHz
// - master parks sck per mode when idle
// - master alone starts transfers and clocks
// - master should send ignored bits as zero
// - three-wire master ties suspend, protect high
// - exactly ten opcodes recognised
// - suspend low freezes sck and select handling
module smsf_dev #(
    parameter int ABITS = `SMSF_ADDR_BITS,
    parameter int DEPTH = `SMSF_MEM_BYTES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // serial pins
    smsf_if.dev pins,
    // decoded command stream
    output logic op_stb,
    output logic [7:0] op_code,
    output logic addr_stb,
    output logic [ABITS-1:0] addr,
    output logic byte_stb,
    output logic [7:0] byte_val,
    // link state
    output logic mode3,
    output logic [7:0] status
);
    import smsf_pkg::*;

    // ****************************************
    // opcode decode
    // ****************************************
    function automatic logic op_known(input logic [7:0] op);
        case (op)
            `SMSF_OP_SETWL, `SMSF_OP_CLRWL, `SMSF_OP_RDST, `SMSF_OP_WRST, `SMSF_OP_READ,
            `SMSF_OP_FREAD, `SMSF_OP_WRITE, `SMSF_OP_SLEEP, `SMSF_OP_RDID, `SMSF_OP_RDSN: op_known = 1'b1;
            default: op_known = 1'b0;
        endcase
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic [1:0] prev_r;
    wire logic [3:0] pin_in = {pins.suspend_b, pins.mosi, pins.sck, pins.cs_b};

    // two flops on every pin before any logic
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_r <= 4'hF;
            sync2_r <= 4'hF;
            prev_r <= 2'h3;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            prev_r <= sync2_r[1:0];
        end
    end

    // edge events, all frozen while suspended
    wire logic cs_s = sync2_r[0];
    wire logic sck_s = sync2_r[1];
    wire logic si_s = sync2_r[2];
    wire logic hold = ~sync2_r[3];
    wire logic cs_fall = ~hold & prev_r[0] & ~cs_s;
    wire logic desel = ~hold & cs_s;
    wire logic sck_rise = ~hold & ~cs_s & ~prev_r[1] & sck_s;
    wire logic sck_fall = ~hold & ~cs_s & prev_r[1] & ~sck_s;

    // ****************************************
    // receive framing
    // ****************************************
    smsf_dev_st_t st_r;
    smsf_dev_st_t st_nxt;
    logic [2:0] bit_r;
    logic [1:0] abyte_r;
    logic [7:0] rx_r;
    logic [7:0] tx_r;
    logic [ABITS-1:0] addr_r;
    logic [7:0] stat_r;
    logic so_r;
    logic oe_r;
    logic [7:0] mem [0:DEPTH-1];

    // incoming byte completes on the eighth rise, msb first
    wire logic [7:0] rx_nxt = {rx_r[6:0], si_s};
    wire logic byte_done = sck_rise & (bit_r == 3'h7);
    wire logic [ABITS-1:0] addr_shift = {addr_r[ABITS-9:0], rx_nxt};
    wire logic [ABITS-1:0] addr_inc = addr_r + 1'b1;
    wire logic last_abyte = (abyte_r == 2'(`SMSF_ADDR_BYTES - 1));
    wire logic drive = (st_r == SD_RDATA || st_r == SD_RSTAT) & ~hold & ~cs_s;

    // next state on byte boundaries
    always_comb begin
        st_nxt = st_r;
        if (byte_done) begin
            unique case (st_r)
                SD_OPC: begin
                    if (!op_known(rx_nxt)) begin
                        st_nxt = SD_IGNORE;
                    end else if (rx_nxt == `SMSF_OP_READ || rx_nxt == `SMSF_OP_FREAD || rx_nxt == `SMSF_OP_WRITE) begin
                        st_nxt = SD_ADDR;
                    end else if (rx_nxt == `SMSF_OP_RDST) begin
                        st_nxt = SD_RSTAT;
                    end else if (rx_nxt == `SMSF_OP_WRST) begin
                        st_nxt = SD_WSTAT;
                    end else begin
                        st_nxt = SD_IGNORE;
                    end
                end
                SD_ADDR: begin
                    if (last_abyte) begin
                        st_nxt = (op_code == `SMSF_OP_WRITE) ? SD_WDATA :
                                 (op_code == `SMSF_OP_FREAD) ? SD_DUMMY : SD_RDATA;
                    end
                end
                SD_DUMMY: st_nxt = SD_RDATA;
                SD_WSTAT: st_nxt = SD_IGNORE;
                SD_IDLE, SD_WDATA, SD_RDATA, SD_RSTAT, SD_IGNORE: st_nxt = st_r;
            endcase
        end
    end

    // framing registers; select fall restarts, deselect parks, neither while suspended
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= SD_IDLE;
            bit_r <= 3'h0;
            abyte_r <= 2'h0;
            rx_r <= 8'h00;
            addr_r <= '0;
            mode3 <= 1'b0;
        end else if (desel) begin
            st_r <= SD_IDLE;
        end else if (cs_fall) begin
            st_r <= SD_OPC;
            bit_r <= 3'h0;
            abyte_r <= 2'h0;
            mode3 <= sck_s;
        end else if (sck_rise && st_r != SD_IGNORE && st_r != SD_IDLE) begin
            // an idle-high clock gives no rise before its first fall
            bit_r <= bit_r + 3'h1;
            rx_r <= rx_nxt;
            st_r <= st_nxt;
            if (byte_done && st_r == SD_ADDR) begin
                addr_r <= addr_shift;
                abyte_r <= abyte_r + 2'h1;
            end else if (byte_done && (st_r == SD_WDATA || st_r == SD_RDATA)) begin
                addr_r <= addr_inc;
            end
        end
    end

    // array writes land as each data byte completes
    always_ff @(posedge core_clk) begin
        if (byte_done && st_r == SD_WDATA && !cs_s && !hold) begin
            mem[addr_r] <= rx_nxt;
        end
    end

    // status register: fixed bits forced, write-latch bit untouched by data
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stat_r <= `SMSF_STAT_RESET;
        end else if (byte_done && st_r == SD_WSTAT && !cs_s) begin
            stat_r <= (rx_nxt & `SMSF_STAT_WMASK) | `SMSF_STAT_FIXED;
        end
    end

    // ****************************************
    // transmit path
    // ****************************************
    wire logic [ABITS-1:0] rd_index = (st_r == SD_ADDR) ? addr_shift : (st_r == SD_RDATA) ? addr_inc : addr_r;

    // load on byte boundary, shift out msb first on each fall
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_r <= 8'h00;
            so_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            oe_r <= drive;
            if (byte_done && st_r == SD_OPC) begin
                tx_r <= stat_r;
            end else if (byte_done && st_r == SD_RSTAT) begin
                tx_r <= stat_r;
            end else if (byte_done && (st_r == SD_ADDR || st_r == SD_DUMMY || st_r == SD_RDATA)) begin
                tx_r <= mem[rd_index];
            end else if (sck_fall && drive) begin
                so_r <= tx_r[7];
                tx_r <= {tx_r[6:0], 1'b0};
            end
        end
    end

    // ****************************************
    // downstream strobes
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            op_stb <= 1'b0;
            op_code <= 8'h00;
            addr_stb <= 1'b0;
            addr <= '0;
            byte_stb <= 1'b0;
            byte_val <= 8'h00;
        end else begin
            op_stb <= byte_done && st_r == SD_OPC && op_known(rx_nxt) && !cs_s;
            addr_stb <= byte_done && st_r == SD_ADDR && last_abyte && !cs_s;
            byte_stb <= byte_done && (st_r == SD_WDATA || st_r == SD_WSTAT) && !cs_s;
            if (byte_done && st_r == SD_OPC) begin
                op_code <= rx_nxt;
            end
            if (byte_done && st_r == SD_ADDR && last_abyte) begin
                addr <= addr_shift;
            end
            if (byte_done) begin
                byte_val <= rx_nxt;
            end
        end
    end

    assign pins.so = so_r;
    assign pins.so_oe = oe_r;
    assign status = stat_r;
endmodule
`default_nettype wire

// File: rtl/smsf_host.sv
// bus master end: makes select and serial clock, shifts one command per request
// assumes the memory end samples pins through two flops on the same core clock
`timescale 1ns/1ns
`default_nettype none
`include "smsf_map.svh"
module smsf_host #(
    parameter int ABITS = `SMSF_ADDR_BITS,
    parameter int HALF = `SMSF_SCK_HALF_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // serial pins
    smsf_if.host pins,
    // command request
    input wire logic req_stb,
    input wire logic [7:0] req_op,
    input wire logic req_addr_en,
    input wire logic [ABITS-1:0] req_addr,
    input wire logic req_dummy,
    input wire logic [7:0] req_len,
    input wire logic req_mode3,
    input wire logic hold_req,
    input wire logic [7:0] wr_byte,
    // status and data back
    output logic busy,
    output logic wr_take,
    output logic rd_stb,
    output logic [7:0] rd_byte,
    output logic done
);
    import smsf_pkg::*;

    smsf_host_st_t st_r;
    logic [7:0] tmr_r;
    logic [2:0] bit_r;
    logic [8:0] byte_r;
    logic [7:0] cur_r;
    logic [7:0] rx_r;
    logic [7:0] op_r;
    logic [23:0] a24_r;
    logic [8:0] hdr_r;
    logic [8:0] total_r;
    logic mode3_r;
    logic cs_b_r;
    logic sck_r;
    logic mosi_r;
    logic hold_b_r;
    logic [1:0] so_sync_r;

    // ****************************************
    // byte selection
    // ****************************************
    wire logic [8:0] nxt_byte = byte_r + 9'h001;
    wire logic tmr_done = (tmr_r == 8'h00);
    wire logic last_bit = (bit_r == 3'h7);
    wire logic is_data = (nxt_byte >= hdr_r);
    wire logic miso_s = so_sync_r[1];
    wire logic [7:0] half_m1 = 8'(HALF - 1);

    // header bytes: opcode, then address msb first, then dummy
    function automatic logic [7:0] pick(input logic [8:0] idx, input logic [23:0] a24, input logic [7:0] wdat,
                                        input logic [8:0] hdr);
        if (idx >= hdr) begin
            pick = wdat;
        end else if (idx == 9'h001) begin
            pick = a24[23:16];
        end else if (idx == 9'h002) begin
            pick = a24[15:8];
        end else if (idx == 9'h003) begin
            pick = a24[7:0];
        end else begin
            pick = 8'h00;
        end
    endfunction
    wire logic [7:0] nxt_val = pick(nxt_byte, a24_r, wr_byte, hdr_r);

    // ****************************************
    // sequencer
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= SH_IDLE;
            tmr_r <= 8'h00;
            bit_r <= 3'h0;
            byte_r <= 9'h000;
            cur_r <= 8'h00;
            rx_r <= 8'h00;
            op_r <= 8'h00;
            a24_r <= 24'h000000;
            hdr_r <= 9'h001;
            total_r <= 9'h001;
            mode3_r <= 1'b0;
            cs_b_r <= 1'b1;
            sck_r <= 1'b0;
            mosi_r <= 1'b0;
            wr_take <= 1'b0;
            rd_stb <= 1'b0;
            rd_byte <= 8'h00;
            done <= 1'b0;
        end else begin
            wr_take <= 1'b0;
            rd_stb <= 1'b0;
            done <= 1'b0;
            tmr_r <= tmr_done ? half_m1 : tmr_r - 8'h01;
            unique case (st_r)
                SH_IDLE: begin
                    sck_r <= req_mode3;
                    tmr_r <= half_m1;
                    if (req_stb) begin
                        // ignored address bits driven as zero
                        a24_r <= {{`SMSF_ADDR_SKIP{1'b0}}, req_addr};
                        hdr_r <= 9'h001 + (req_addr_en ? 9'h003 : 9'h000) + {8'h00, req_dummy};
                        total_r <= 9'h001 + (req_addr_en ? 9'h003 : 9'h000) + {8'h00, req_dummy} + {1'b0, req_len};
                        op_r <= req_op;
                        mode3_r <= req_mode3;
                        cs_b_r <= 1'b0;
                        st_r <= SH_SEL;
                    end
                end
                SH_SEL: begin
                    if (tmr_done) begin
                        sck_r <= 1'b0;
                        cur_r <= op_r;
                        mosi_r <= op_r[7];
                        bit_r <= 3'h0;
                        byte_r <= 9'h000;
                        st_r <= SH_LO;
                    end
                end
                SH_LO: begin
                    if (tmr_done) begin
                        sck_r <= 1'b1;
                        st_r <= SH_HI;
                    end
                end
                SH_HI: begin
                    if (tmr_done) begin
                        rx_r <= {rx_r[6:0], miso_s};
                        bit_r <= bit_r + 3'h1;
                        if (last_bit && byte_r >= hdr_r) begin
                            rd_stb <= 1'b1;
                            rd_byte <= {rx_r[6:0], miso_s};
                        end
                        if (last_bit && nxt_byte == total_r) begin
                            sck_r <= mode3_r;
                            st_r <= SH_END;
                        end else begin
                            sck_r <= 1'b0;
                            st_r <= SH_LO;
                            if (last_bit) begin
                                byte_r <= nxt_byte;
                                cur_r <= nxt_val;
                                mosi_r <= nxt_val[7];
                                wr_take <= is_data;
                            end else begin
                                mosi_r <= cur_r[3'h6 - bit_r];
                            end
                        end
                    end
                end
                SH_END: begin
                    if (tmr_done) begin
                        cs_b_r <= 1'b1;
                        done <= 1'b1;
                        st_r <= SH_IDLE;
                    end
                end
            endcase
        end
    end

    // serial output synchroniser and pin flops
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            so_sync_r <= 2'h3;
            hold_b_r <= 1'b1;
            busy <= 1'b0;
        end else begin
            so_sync_r <= {so_sync_r[0], pins.miso};
            hold_b_r <= ~hold_req;
            busy <= (st_r != SH_IDLE) | req_stb;
        end
    end

    assign pins.cs_b = cs_b_r;
    assign pins.sck = sck_r;
    assign pins.mosi = mosi_r;
    assign pins.suspend_b = hold_b_r;
    assign pins.wp_b = 1'b1;
endmodule
`default_nettype wire

// File: rtl/smsf_if.sv
// serial link between bus master and memory front end
// assumes both ends run on one core clock; serial output pulled high when released
`timescale 1ns/1ns
`default_nettype none
interface smsf_if;
    logic cs_b;
    logic sck;
    logic mosi;
    logic so;
    logic so_oe;
    logic suspend_b;
    logic wp_b;
    logic miso;
    // released serial output reads as pulled-up high
    assign miso = so_oe ? so : 1'b1;
    modport dev (input cs_b, input sck, input mosi, input suspend_b, input wp_b, output so, output so_oe);
    modport host (output cs_b, output sck, output mosi, output suspend_b, output wp_b, input miso);
endinterface
`default_nettype wire

// File: rtl/smsf_map.svh
// constants for the serial memory spi front end: opcodes, sizes, timing
// assumes nothing; included by the package and both ends
`ifndef SMSF_MAP_SVH
`define SMSF_MAP_SVH

// ****************************************
// array geometry and addressing
// ****************************************
`define SMSF_MEM_BYTES 131072
`define SMSF_ADDR_BITS 17
`define SMSF_ADDR_BYTES 3
`define SMSF_ADDR_SKIP 7

// ****************************************
// opcodes
// ****************************************
`define SMSF_OP_SETWL 8'h06
`define SMSF_OP_CLRWL 8'h04
`define SMSF_OP_RDST 8'h05
`define SMSF_OP_WRST 8'h01
`define SMSF_OP_READ 8'h03
`define SMSF_OP_FREAD 8'h0B
`define SMSF_OP_WRITE 8'h02
`define SMSF_OP_SLEEP 8'hB9
`define SMSF_OP_RDID 8'h9F
`define SMSF_OP_RDSN 8'hC3

// ****************************************
// configuration and status register
// ****************************************
`define SMSF_STAT_RESET 8'h40
`define SMSF_STAT_WMASK 8'h8C
`define SMSF_STAT_FIXED 8'h40

// ****************************************
// timing
// ****************************************
`define SMSF_CLK_NS 40
`define SMSF_SCK_HALF_NS 160
`define SMSF_SCK_HALF_CYC ((`SMSF_SCK_HALF_NS + `SMSF_CLK_NS - 1) / `SMSF_CLK_NS)

`endif

// File: rtl/smsf_pkg.sv
// types shared by both ends of the serial memory spi link
// assumes smsf_map.svh is on the include path
`include "smsf_map.svh"
package smsf_pkg;
    typedef enum logic [3:0] {
        SD_IDLE, SD_OPC, SD_ADDR, SD_DUMMY, SD_WDATA, SD_RDATA, SD_WSTAT, SD_RSTAT, SD_IGNORE
    } smsf_dev_st_t;
    typedef enum logic [2:0] {SH_IDLE, SH_SEL, SH_LO, SH_HI, SH_END} smsf_host_st_t;
endpackage

// File: testbench/serial_memory_spi_slave_frontend_tb.sv
// bench joining master end and memory end across the link interface
// assumes default host half period; drives requests 1 ns after rise
`timescale 1ns/1ns
`default_nettype none
module serial_memory_spi_slave_frontend_tb;
    // ****************************************
    // signals
    // ****************************************
    logic core_clk, rst_b, req_stb, req_addr_en, req_dummy, req_mode3, hold_req;
    logic [7:0] req_op, req_len, wr_byte, rd_byte, op_code, byte_val, status;
    logic [16:0] req_addr, addr, cap_addr;
    logic busy, wr_take, rd_stb, done, op_stb, addr_stb, byte_stb, mode3;
    logic [7:0] wr_arr [4];
    logic [7:0] rd_arr [64];
    logic [7:0] by_arr [64];
    logic [31:0] wr_diff;
    int rd_n, by_n, op_n, wr_cnt, wr_mark, rb, bb, ob, bad_count, n_checks, cyc, i;
    logic [7:0] ops [5] = '{8'h06, 8'h04, 8'hB9, 8'h9F, 8'hC3};
    assign wr_diff = wr_cnt - wr_mark;
    assign wr_byte = wr_arr[wr_diff[1:0]];
    smsf_if link();
    smsf_host smsf_host_inst (.core_clk(core_clk), .rst_b(rst_b), .pins(link), .req_stb(req_stb),
        .req_op(req_op), .req_addr_en(req_addr_en), .req_addr(req_addr), .req_dummy(req_dummy),
        .req_len(req_len), .req_mode3(req_mode3), .hold_req(hold_req), .wr_byte(wr_byte), .busy(busy),
        .wr_take(wr_take), .rd_stb(rd_stb), .rd_byte(rd_byte), .done(done));
    smsf_dev smsf_dev_inst (.core_clk(core_clk), .rst_b(rst_b), .pins(link), .op_stb(op_stb),
        .op_code(op_code), .addr_stb(addr_stb), .addr(addr), .byte_stb(byte_stb), .byte_val(byte_val),
        .mode3(mode3), .status(status));
    smsf_properties smsf_properties_inst (.core_clk(core_clk), .rst_b(rst_b), .cs_b(link.cs_b),
        .sck(link.sck), .mosi(link.mosi), .so(link.so), .so_oe(link.so_oe), .suspend_b(link.suspend_b),
        .wp_b(link.wp_b), .miso(link.miso));
    // clock at 25 MHz
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // collects strobed outputs of both ends, cuts a hang short
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (rd_stb === 1'b1) begin rd_arr[rd_n] <= rd_byte; rd_n <= rd_n + 1; end
        if (byte_stb === 1'b1) begin by_arr[by_n] <= byte_val; by_n <= by_n + 1; end
        if (op_stb === 1'b1) op_n <= op_n + 1;
        if (addr_stb === 1'b1) cap_addr <= addr;
        if (wr_take === 1'b1) wr_cnt <= wr_cnt + 1;
        if (cyc > 20000) begin bad_count++; finish_test(); end
    end
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask
    task automatic cmd(input logic [7:0] op, input logic ae, input logic [16:0] a, input logic dm,
                       input logic [7:0] ln, input logic m3);
        int k;
        rb = rd_n; bb = by_n; ob = op_n; wr_mark = wr_cnt;
        {req_op, req_addr_en, req_addr, req_dummy, req_len, req_mode3} = {op, ae, a, dm, ln, m3};
        req_stb = 1'b1;
        @(posedge core_clk); #1;
        req_stb = 1'b0;
        chk(busy, 24'h1);
        k = 0;
        while (done !== 1'b1 && k < 5000) begin @(posedge core_clk); #1; k++; end
        if (k >= 5000) bad_count++;
        repeat (12) @(posedge core_clk); #1;
        chk(busy, 24'h0);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {rst_b, req_stb, req_addr_en, req_dummy, req_mode3, hold_req, req_op, req_len, req_addr} = '0;
        {rd_n, by_n, op_n, wr_cnt, wr_mark, bad_count, n_checks, cyc} = '0;
        wr_arr = '{8'h5A, 8'hC3, 8'hFF, 8'h00};
        repeat (20) @(posedge core_clk); #1;
        rst_b = 1'b1;
        chk(status, 24'h40);
        // two bytes at the top address, second wraps to zero
        cmd(8'h02, 1'b1, 17'h1FFFF, 1'b0, 8'd2, 1'b0);
        chk(cap_addr, 24'h1FFFF);
        chk(by_arr[bb], 24'h5A);
        chk(by_arr[bb+1], 24'hC3);
        chk(op_code, 24'h02);
        chk(mode3, 24'h0);
        $display("test write done");
        // read back with clock idling high
        cmd(8'h03, 1'b1, 17'h1FFFF, 1'b0, 8'd2, 1'b1);
        chk(mode3, 24'h1);
        chk(rd_arr[rb], 24'h5A);
        chk(rd_arr[rb+1], 24'hC3);
        $display("test mode3 read done");
        cmd(8'h0B, 1'b1, 17'h00000, 1'b1, 8'd1, 1'b0);
        chk(mode3, 24'h0);
        chk(rd_arr[rb], 24'hC3);
        $display("test fast read done");
        // status write then repeated status read
        wr_arr = '{8'hFF, 8'hFF, 8'hFF, 8'hFF};
        cmd(8'h01, 1'b0, 17'h0, 1'b0, 8'd1, 1'b0);
        chk(status, 24'hCC);
        cmd(8'h05, 1'b0, 17'h0, 1'b0, 8'd2, 1'b1);
        chk(rd_arr[rb], 24'hCC);
        chk(rd_arr[rb+1], 24'hCC);
        $display("test status done");
        // suspend held through a whole status write: nothing is taken
        wr_arr = '{8'h00, 8'h00, 8'h00, 8'h00};
        hold_req = 1'b1;
        repeat (4) @(posedge core_clk); #1;
        cmd(8'h01, 1'b0, 17'h0, 1'b0, 8'd1, 1'b0);
        hold_req = 1'b0;
        repeat (4) @(posedge core_clk); #1;
        chk(status, 24'hCC);
        chk(op_n - ob, 24'h0);
        chk(by_n - bb, 24'h0);
        $display("test suspend done");
        // unknown opcode: no decode, output stays released
        cmd(8'hA5, 1'b0, 17'h0, 1'b0, 8'd2, 1'b0);
        chk(op_n - ob, 24'h0);
        chk(rd_arr[rb], 24'hFF);
        chk(rd_arr[rb+1], 24'hFF);
        $display("test bad opcode done");
        // remaining opcodes each decoded once
        for (i = 0; i < 5; i++) begin
            cmd(ops[i], 1'b0, 17'h0, 1'b0, 8'd0, i[0]);
            chk(op_n - ob, 24'h1);
            chk(op_code, ops[i]);
        end
        $display("test opcode list done");
        finish_test();
    end
endmodule
`default_nettype wire

// File: testbench/smsf_properties.sv
// link checker: timing and framing relations on the serial pins
// assumes it watches the interface joining both ends, on the same core clock
`timescale 1ns/1ns
`default_nettype none
module smsf_properties (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // link pins
    input wire logic cs_b,
    input wire logic sck,
    input wire logic mosi,
    input wire logic so,
    input wire logic so_oe,
    input wire logic suspend_b,
    input wire logic wp_b,
    input wire logic miso
);
    // ****************************************
    // helper logic
    // ****************************************
    logic sck_r, cs_r, sck_sel_r;
    logic [7:0] op_r;
    logic [4:0] rises_r;
    wire rise_w = sck && !sck_r && !cs_b && suspend_b;
    wire sel_w = !cs_b && cs_r;
    wire known_w = op_r inside {8'h06, 8'h04, 8'h05, 8'h01, 8'h03, 8'h0B, 8'h02, 8'hB9, 8'h9F, 8'hC3};
    // counts sck rises per frame and gathers the opcode byte
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            {sck_r, sck_sel_r, op_r, rises_r} <= '0;
            cs_r <= 1'b1;
        end else begin
            sck_r <= sck;
            cs_r <= cs_b;
            if (sel_w) begin
                sck_sel_r <= sck;
                rises_r <= 5'h00;
            end else if (rise_w && rises_r != 5'h1F) begin
                rises_r <= rises_r + 5'h01;
            end
            if (rise_w && rises_r < 5'h08) begin
                op_r <= {op_r[6:0], mosi};
            end
        end
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence s_opcode_in;
        !cs_b && rises_r >= 5'h08;
    endsequence
    property p_desel_release; cs_b [*6] |-> !so_oe; endproperty
    a_desel_release: assert property (p_desel_release) else $error("output driven while deselected");
    property p_oe_after_opcode; so_oe && !cs_b |-> rises_r >= 5'h08; endproperty
    a_oe_after_opcode: assert property (p_oe_after_opcode) else $error("output driven before opcode");
    property p_bad_op_quiet; s_opcode_in ##0 !known_w |-> !so_oe; endproperty
    a_bad_op_quiet: assert property (p_bad_op_quiet) else $error("output driven after bad opcode");
    property p_so_on_fall; $fell(sck) && so_oe |-> $stable(so) [*3]; endproperty
    a_so_on_fall: assert property (p_so_on_fall) else $error("output moved too soon after fall");
    property p_sck_half; $changed(sck) |=> $stable(sck) [*3]; endproperty
    a_sck_half: assert property (p_sck_half) else $error("serial clock phase too short");
    property p_wp_tied; wp_b; endproperty
    a_wp_tied: assert property (p_wp_tied) else $error("protect input not held high");
    property p_mode_park; $rose(cs_b) |-> sck == sck_sel_r; endproperty
    a_mode_park: assert property (p_mode_park) else $error("clock not parked at mode level");
    property p_cs_gap; $rose(cs_b) |-> cs_b [*2]; endproperty
    a_cs_gap: assert property (p_cs_gap) else $error("select gap too short");
    property p_hold_quiet; !suspend_b [*4] |-> !so_oe && miso; endproperty
    a_hold_quiet: assert property (p_hold_quiet) else $error("output driven while suspended");
endmodule
`default_nettype wire
